// ---- src/prgca_counter_array.sv ----
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module prgca_counter_array
  import prgca_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic idleMode,
  input wire logic timer0Overflow,
  input wire logic externalCountInput,
  input wire logic [NUM_MOD-1:0] modulePinIn,
  output logic [NUM_MOD-1:0] modulePinOut,
  output logic [NUM_MOD-1:0] modulePinOe,
  output logic watchdogReset,
  output logic irq
);

  // ==========================================================
  // State
  prgca_state_t st_r; // Registered state
  prgca_state_t st_nxt; // Next state
  logic busReq; // Any request present
  logic accept; // Request completes this edge
  logic wrHit; // Write completes this edge
  logic tick12; // Oscillator over 12
  logic tick4; // Oscillator over 4
  logic eciFall; // External count edge
  logic srcTick; // Selected source pulse
  logic halted; // Idle stop in force
  logic inc; // Counter steps this edge
  logic [15:0] cntNext; // Counter plus one
  logic ovf; // Counter wraps this edge
  logic cntWr; // Software writes the counter
  logic flagWr; // Software touches flag bits
  logic [NUM_MOD-1:0] capVec; // Capture events
  logic [NUM_MOD-1:0] matchVec; // Compare events
  logic [NUM_MOD-1:0] evtSet; // Flag set requests
  logic [NUM_MOD:0] gateVec; // Per-source interrupt gates

  // ==========================================================
  // Slot decode for per-module register banks
  function automatic logic [3:0] slotOf(input logic [7:0] addr, input logic [7:0] base);
    logic hit;
    hit = (addr[7:5] == base[7:5]) && (addr[1:0] == 2'h0) && (addr[4:2] < 3'h5);
    return {hit, addr[4:2]};
  endfunction : slotOf

  // ==========================================================
  // Outputs
  assign avs_readdata = st_r.rdata;
  // One wait cycle, then the answer; a new request restarts
  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & (st_r.bus != BUS_ACK);
  assign accept = busReq & (st_r.bus == BUS_ACK);
  assign wrHit = accept & avs_write;
  assign modulePinOut = st_r.pinOut;
  assign watchdogReset = st_r.wdogRst;
  assign irq = st_r.irq;

  // Drive the pin whenever a mode owns it as an output
  always_comb
  begin
    for (int i = 0; i < NUM_MOD; i++)
    begin
      modulePinOe[i] = st_r.modMode[i][MM_TOGGLE_BIT] | st_r.modMode[i][MM_PWM_BIT];
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [3:0] slot;
    logic [7:0] mm;
    logic rise;
    logic fall;
    slot = 4'h0;
    mm = 8'h00;
    rise = 1'b0;
    fall = 1'b0;
    st_nxt = st_r;
    capVec = '0;
    matchVec = '0;
    evtSet = '0;
    cntWr = 1'b0;
    flagWr = 1'b0;

    // Bus handshake; illegal codes fall back to idle
    unique case (st_r.bus)
      BUS_IDLE:
      begin
        if (busReq)
        begin
          st_nxt.bus = BUS_ACK;
        end
      end
      BUS_ACK:
      begin
        st_nxt.bus = BUS_IDLE;
      end
      default:
      begin
        st_nxt.bus = BUS_IDLE;
      end
    endcase

    // Read data latched while waiting; unmapped reads give zero
    if ((st_r.bus == BUS_IDLE) && avs_read)
    begin
      st_nxt.rdata = 32'h0000_0000;
      case (avs_address)
        OFS_ARRAY_MODE: st_nxt.rdata[7:0] = st_r.arrMode;
        OFS_RUN_FLAGS: st_nxt.rdata[7:0] = {st_r.ovfFlag, st_r.run, 1'b0, st_r.evtFlag};
        OFS_EVT_STATUS: st_nxt.rdata[NUM_MOD:0] = {st_r.ovfFlag, st_r.evtFlag};
        OFS_EVT_ENABLE: st_nxt.rdata[NUM_MOD:0] = st_r.irqEn;
        OFS_COUNTER: st_nxt.rdata[15:0] = st_r.count;
        default:
        begin
          slot = slotOf(avs_address, OFS_MOD_MODE_BASE);
          if (slot[3])
          begin
            st_nxt.rdata[7:0] = st_r.modMode[slot[2:0]];
          end
          slot = slotOf(avs_address, OFS_MOD_VALUE_BASE);
          if (slot[3])
          begin
            st_nxt.rdata[15:0] = st_r.modValue[slot[2:0]];
          end
        end
      endcase
    end

    // Prescalers run freely so the source phase is unaffected by run
    tick12 = (st_r.div12Cnt == DIV12_LAST);
    tick4 = (st_r.div4Cnt == DIV4_LAST);
    st_nxt.div12Cnt = tick12 ? 4'h0 : st_r.div12Cnt + 4'h1;
    st_nxt.div4Cnt = st_r.div4Cnt + 2'h1;

    // External count pin: two-stage sync, falling edge counts
    st_nxt.eciSync = {st_r.eciSync[0], externalCountInput};
    st_nxt.eciPrev = st_r.eciSync[1];
    eciFall = st_r.eciPrev & ~st_r.eciSync[1];

    // Source select
    unique case ({st_r.arrMode[MODE_SRC_HI_BIT], st_r.arrMode[MODE_SRC_LO_BIT]})
      SRC_DIV12: srcTick = tick12;
      SRC_DIV4: srcTick = tick4;
      SRC_TIMER0: srcTick = timer0Overflow;
      SRC_EXT: srcTick = eciFall;
    endcase

    halted = st_r.arrMode[MODE_IDLE_STOP_BIT] & idleMode;
    inc = st_r.run & ~halted & srcTick;
    cntNext = st_r.count + 16'h0001;
    ovf = inc & (st_r.count == 16'hFFFF);
    if (inc)
    begin
      st_nxt.count = cntNext;
    end

    // Capture pins: sync, then edge from the second stage only
    st_nxt.pinSync1 = modulePinIn;
    st_nxt.pinSync2 = st_r.pinSync1;
    st_nxt.pinPrev = st_r.pinSync2;

    // Per-module compare, capture, toggle and PWM
    for (int i = 0; i < NUM_MOD; i++)
    begin
      mm = st_r.modMode[i];
      rise = st_r.pinSync2[i] & ~st_r.pinPrev[i];
      fall = st_r.pinPrev[i] & ~st_r.pinSync2[i];
      capVec[i] = (mm[MM_CAP_RISE_BIT] & rise) | (mm[MM_CAP_FALL_BIT] & fall);
      // Compared against the value the counter steps to, only on a step
      matchVec[i] = inc & mm[MM_COMP_EN_BIT] & ~mm[MM_PWM_BIT]
        & (cntNext == st_r.modValue[i]);
      if (capVec[i])
      begin
        st_nxt.modValue[i] = st_r.count;
      end
      evtSet[i] = capVec[i] | (matchVec[i] & mm[MM_MATCH_FLAG_BIT]);
      if (matchVec[i] & mm[MM_TOGGLE_BIT])
      begin
        st_nxt.pinOut[i] = ~st_r.pinOut[i];
      end
      if (mm[MM_PWM_BIT] & mm[MM_COMP_EN_BIT])
      begin
        // Duty byte reloads from the high byte at each low-byte wrap
        if (inc && (st_r.count[7:0] == 8'hFF))
        begin
          st_nxt.modValue[i][7:0] = st_r.modValue[i][15:8];
        end
      end
    end

    // Watchdog pulse on a module 4 match when enabled
    st_nxt.wdogRst = st_r.arrMode[MODE_WDOG_EN_BIT] & matchVec[WDOG_MOD];

    // Software writes, applied before hardware sets so sets win
    if (wrHit)
    begin
      case (avs_address)
        OFS_ARRAY_MODE:
        begin
          if (avs_byteenable[0])
          begin
            st_nxt.arrMode = avs_writedata[7:0];
          end
        end
        OFS_RUN_FLAGS:
        begin
          if (avs_byteenable[0])
          begin
            flagWr = 1'b1;
            st_nxt.run = avs_writedata[RUN_CTRL_BIT];
            st_nxt.ovfFlag = avs_writedata[RUN_OVF_FLAG_BIT];
            st_nxt.evtFlag = avs_writedata[NUM_MOD-1:0];
          end
        end
        OFS_EVT_CLEAR:
        begin
          if (avs_byteenable[0])
          begin
            flagWr = 1'b1;
            st_nxt.ovfFlag = st_r.ovfFlag & ~avs_writedata[STAT_OVF_BIT];
            st_nxt.evtFlag = st_r.evtFlag & ~avs_writedata[NUM_MOD-1:0];
          end
        end
        OFS_EVT_ENABLE:
        begin
          if (avs_byteenable[0])
          begin
            st_nxt.irqEn = avs_writedata[NUM_MOD:0];
          end
        end
        OFS_COUNTER:
        begin
          cntWr = avs_byteenable[0] | avs_byteenable[1];
          if (avs_byteenable[0])
          begin
            st_nxt.count[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1])
          begin
            st_nxt.count[15:8] = avs_writedata[15:8];
          end
        end
        default:
        begin
          slot = slotOf(avs_address, OFS_MOD_MODE_BASE);
          if (slot[3] && avs_byteenable[0])
          begin
            st_nxt.modMode[slot[2:0]] = avs_writedata[7:0];
          end
          slot = slotOf(avs_address, OFS_MOD_VALUE_BASE);
          if (slot[3])
          begin
            if (avs_byteenable[0])
            begin
              st_nxt.modValue[slot[2:0]][7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1])
            begin
              st_nxt.modValue[slot[2:0]][15:8] = avs_writedata[15:8];
            end
          end
        end
      endcase
    end

    // Hardware sets, never clears
    st_nxt.ovfFlag = st_nxt.ovfFlag | ovf;
    st_nxt.evtFlag = st_nxt.evtFlag | evtSet;

    // PWM level follows the next counter and duty byte
    for (int i = 0; i < NUM_MOD; i++)
    begin
      if (st_nxt.modMode[i][MM_PWM_BIT] & st_nxt.modMode[i][MM_COMP_EN_BIT])
      begin
        st_nxt.pinOut[i] = (st_nxt.count[7:0] >= st_nxt.modValue[i][7:0]);
      end
      gateVec[i] = st_nxt.modMode[i][MM_IRQ_EN_BIT];
    end
    gateVec[STAT_OVF_BIT] = st_nxt.arrMode[MODE_OVF_IE_BIT];

    // Interrupt: status, enable register and per-source gate all needed
    st_nxt.irq = |({st_nxt.ovfFlag, st_nxt.evtFlag} & st_nxt.irqEn & gateVec);
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
      st_r.bus <= BUS_IDLE;
      st_r.arrMode <= RST_MODE;
      st_r.count <= RST_VALUE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  AST_STOPPED_HOLDS: assert property ((!st_r.run && !cntWr) |=> $stable(st_r.count))
    else $error("Counter moved while stopped");

  AST_STEP_BY_ONE: assert property ((inc && !cntWr) |=> st_r.count == $past(cntNext))
    else $error("Counter did not step by one");

  AST_DIV12_PERIOD: assert property (tick12 |-> ##12 tick12)
    else $error("Divide-by-12 period wrong");

  AST_DIV12_GAP: assert property (tick12 |=> (!tick12) [*8])
    else $error("Divide-by-12 tick too early");

  AST_IDLE_HALT: assert property ((st_r.arrMode[MODE_IDLE_STOP_BIT] && idleMode) |-> !inc)
    else $error("Counter stepped in idle with idle stop");

  AST_OVF_SETS: assert property ((ovf && !cntWr) |=> st_r.ovfFlag && st_r.count == 16'h0000)
    else $error("Overflow did not set flag");

  AST_OVF_STICKY: assert property ((st_r.ovfFlag && !flagWr) |=> st_r.ovfFlag)
    else $error("Overflow flag cleared without software");

  AST_EVT_STICKY: assert property ((st_r.evtFlag[0] && !flagWr) |=> st_r.evtFlag[0])
    else $error("Module flag cleared without software");

  AST_NO_GATE_NO_IRQ: assert property ((gateVec == '0) [*2] |-> !st_r.irq)
    else $error("Interrupt with every gate closed");

  AST_CAPTURE: assert property ((capVec[1] && !wrHit) |=>
    st_r.modValue[1] == $past(st_r.count) && st_r.evtFlag[1])
    else $error("Capture lost value or flag");

  AST_TOGGLE: assert property ((matchVec[0] && st_r.modMode[0][MM_TOGGLE_BIT] && !wrHit) |=>
    st_r.pinOut[0] != $past(st_r.pinOut[0]))
    else $error("Pin did not toggle on match");

  AST_MATCH_FLAG: assert property ((matchVec[0] && st_r.modMode[0][MM_MATCH_FLAG_BIT]) |=>
    st_r.evtFlag[0])
    else $error("Match did not set flag");

  AST_ONE_MATCH: assert property (matchVec[0] |=> !matchVec[0])
    else $error("Match repeated for one counter value");

  AST_WDOG: assert property ((matchVec[WDOG_MOD] && st_r.arrMode[MODE_WDOG_EN_BIT]) |=>
    watchdogReset ##1 (!watchdogReset || $past(matchVec[WDOG_MOD])))
    else $error("Watchdog pulse missing");

  AST_BUS_ONE_WAIT: assert property ((busReq && st_r.bus == BUS_IDLE) |-> avs_waitrequest ##1
    (!busReq || !avs_waitrequest))
    else $error("Bus answer not after one wait cycle");

  COV_OVERFLOW: cover property (ovf ##1 st_r.irq);
  COV_CAPTURE: cover property (capVec[1]);
  COV_TOGGLE: cover property (matchVec[0] && st_r.modMode[0][MM_TOGGLE_BIT]);
  COV_WATCHDOG: cover property (watchdogReset);

endmodule : prgca_counter_array

// ---- src/prgca_pkg.sv ----
// Function
// - One shared 16-bit counter for five modules
// - Each module owns one pin, all modes
// - Two-bit field selects the count source
// - Idle-stop bit halts counting in idle
// - Watchdog enable gates module 4 watchdog
// - Overflow sets flag bit 7, gated interrupt
// - Overflow flag cleared by software only
// - Run bit 6 starts and stops counter
// - Bits 0-4 are sticky module event flags
// - Mode bit 0 enables module interrupt
// - Mode bit 1 enables PWM output
// - Mode bit 2 toggles pin on match
// - Mode bit 3 sets flag on match
// - Mode bits 4/5 capture falling/rising edges
// - Mode bit 6 enables the comparator
// - Value register captures, compares or sets duty
package prgca_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_MOD = 5;
  localparam int WDOG_MOD = 4;

  // ==========================================================
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_ARRAY_MODE = 8'h00;
  localparam logic [7:0] OFS_RUN_FLAGS = 8'h04;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h10;
  localparam logic [7:0] OFS_COUNTER = 8'h14;
  localparam logic [7:0] OFS_MOD_MODE_BASE = 8'h20;
  localparam logic [7:0] OFS_MOD_VALUE_BASE = 8'h40;

  // ==========================================================
  // Array mode control fields
  localparam int MODE_IDLE_STOP_BIT = 7;
  localparam int MODE_WDOG_EN_BIT = 6;
  localparam int MODE_SRC_HI_BIT = 2;
  localparam int MODE_SRC_LO_BIT = 1;
  localparam int MODE_OVF_IE_BIT = 0;

  // Run and flags fields
  localparam int RUN_OVF_FLAG_BIT = 7;
  localparam int RUN_CTRL_BIT = 6;

  // Module mode control fields
  localparam int MM_IRQ_EN_BIT = 0;
  localparam int MM_PWM_BIT = 1;
  localparam int MM_TOGGLE_BIT = 2;
  localparam int MM_MATCH_FLAG_BIT = 3;
  localparam int MM_CAP_FALL_BIT = 4;
  localparam int MM_CAP_RISE_BIT = 5;
  localparam int MM_COMP_EN_BIT = 6;

  // Status layout: bits 0-4 module events, bit 5 overflow
  localparam int STAT_OVF_BIT = 5;

  // ==========================================================
  // Count sources
  localparam logic [1:0] SRC_DIV12 = 2'h0;
  localparam logic [1:0] SRC_DIV4 = 2'h1;
  localparam logic [1:0] SRC_TIMER0 = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_VALUE = 16'h0000;

  // ==========================================================
  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } prgca_bus_t;

  // ==========================================================
  // Whole block state
  typedef struct packed {
    prgca_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] arrMode;
    logic run;
    logic ovfFlag;
    logic [NUM_MOD-1:0] evtFlag;
    logic [NUM_MOD:0] irqEn;
    logic [15:0] count;
    logic [3:0] div12Cnt;
    logic [1:0] div4Cnt;
    logic [1:0] eciSync;
    logic eciPrev;
    logic [NUM_MOD-1:0] pinSync1;
    logic [NUM_MOD-1:0] pinSync2;
    logic [NUM_MOD-1:0] pinPrev;
    logic [NUM_MOD-1:0][7:0] modMode;
    logic [NUM_MOD-1:0][15:0] modValue;
    logic [NUM_MOD-1:0] pinOut;
    logic wdogRst;
    logic irq;
  } prgca_state_t;

endpackage : prgca_pkg

// ---- test/prgca_pin_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// Far side of the pins: capture sources, count pin, timer pulse
module prgca_pin_model
  import prgca_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_MOD-1:0] modulePinOut,
  input wire logic [NUM_MOD-1:0] modulePinOe,
  output logic [NUM_MOD-1:0] modulePinIn,
  output logic externalCountInput,
  output logic timer0Overflow
);
  logic [NUM_MOD-1:0] drv; // Level this side puts on each pin

  // Wire level: the block wins where it drives the pin
  assign modulePinIn = (modulePinOe & modulePinOut) | (~modulePinOe & drv);

  // Idle levels; count pin rests high so only a fall counts
  initial
  begin
    drv = '0;
    externalCountInput = 1'b1;
    timer0Overflow = 1'b0;
  end

  // One-cycle overflow pulses from the companion timer
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      timer0Overflow <= 1'b1;
      @(posedge core_clk);
      timer0Overflow <= 1'b0;
    end
  endtask : tick

  // Slow count-pin pulses, so the synchroniser sees each level
  task automatic extFall(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      externalCountInput <= 1'b0;
      repeat (4) @(posedge core_clk);
      externalCountInput <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
  endtask : extFall

  // Pin change, then room for the two-stage synchroniser
  task automatic setPin(input int k, input logic v);
    @(posedge core_clk);
    drv[k] <= v;
    repeat (5) @(posedge core_clk);
  endtask : setPin
endmodule : prgca_pin_model

// ---- test/prgca_counter_array_tb_top.sv ----
`timescale 1ns/100ps
// ==========================================================
// Bench: bus tasks plus rule scenarios
module prgca_counter_array_tb_top
  import prgca_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable; // Lanes 0 and 1 matter; one test uses lane 0 alone
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic idleMode;
  logic t0Ovf, extCount, wdReset, irq;
  logic [NUM_MOD-1:0] pinIn, pinOut, pinOe;
  int fails = 0;
  int nChecks = 0;
  int cycles = 0;
  int wdPulses = 0; // Watchdog pulses seen
  logic [31:0] v;

  always #2.5 core_clk = ~core_clk;

  prgca_counter_array uut (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idleMode(idleMode), .timer0Overflow(t0Ovf), .externalCountInput(extCount),
    .modulePinIn(pinIn), .modulePinOut(pinOut), .modulePinOe(pinOe),
    .watchdogReset(wdReset), .irq(irq));

  prgca_pin_model pins (.core_clk(core_clk), .modulePinOut(pinOut),
    .modulePinOe(pinOe), .modulePinIn(pinIn), .externalCountInput(extCount),
    .timer0Overflow(t0Ovf));

  // Count single-cycle watchdog pulses; a stuck level counts many
  always @(posedge core_clk)
    if (wdReset === 1'b1)
      wdPulses <= wdPulses + 1;

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end

  // ==========================================================
  // Verdict and end of run
  task automatic summarize();
    if (fails == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================
  // Avalon accesses: hold until waitrequest is seen low
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge core_clk); // Gap so the strobe is not reasserted at once
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rc

  // ==========================================================
  // Main sequence
  initial
  begin
    arst_n <= 1'b0;
    avs_address <= 8'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0000_0000;
    avs_byteenable <= 4'h3;
    idleMode <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rc(OFS_RUN_FLAGS, 32'h0000_0000);
    rc(OFS_COUNTER, 32'h0000_0000);
    rc(8'h80, 32'h0000_0000);
    // Byte lanes: a lane-0-only write leaves the high byte alone
    wr(OFS_COUNTER, 32'h0000_1234);
    avs_byteenable <= 4'h1;
    wr(OFS_COUNTER, 32'h0000_ABCD);
    avs_byteenable <= 4'h3;
    rc(OFS_COUNTER, 32'h0000_12CD);
    wr(OFS_EVT_STATUS, 32'h0000_00FF);
    rc(OFS_EVT_STATUS, 32'h0000_0000);
    // Internal dividers: 51 cycles of run give a known tick count
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_ARRAY_MODE, {29'h0, (i == 0) ? SRC_DIV4 : SRC_DIV12, 1'b0});
      wr(OFS_COUNTER, 32'h0000_0000);
      wr(OFS_RUN_FLAGS, 32'h0000_0040);
      repeat (48) @(posedge core_clk);
      wr(OFS_RUN_FLAGS, 32'h0000_0000);
      rd(OFS_COUNTER, v);
      chk({31'h0, (i == 0) ? (v >= 12 && v <= 13) : (v >= 4 && v <= 5)}, 1);
    end
    wr(OFS_ARRAY_MODE, 32'h0000_0006);
    wr(OFS_COUNTER, 32'h0000_0000);
    wr(OFS_RUN_FLAGS, 32'h0000_0040);
    pins.extFall(2);
    rc(OFS_COUNTER, 32'h0000_0002);
    // Overflow through the timer source, with and without enable
    wr(OFS_ARRAY_MODE, 32'h0000_0005);
    wr(OFS_COUNTER, 32'h0000_FFFF);
    wr(OFS_EVT_ENABLE, 32'h0000_0020);
    pins.tick(1);
    rc(OFS_COUNTER, 32'h0000_0000);
    rc(OFS_RUN_FLAGS, 32'h0000_00C0);
    chk({31'h0, irq}, 1);
    wr(OFS_ARRAY_MODE, 32'h0000_0004);
    chk({31'h0, irq}, 0);
    rc(OFS_EVT_STATUS, 32'h0000_0020);
    wr(OFS_EVT_CLEAR, 32'h0000_0020);
    rc(OFS_RUN_FLAGS, 32'h0000_0040);
    // Module 0 compare: toggle, flag, interrupt, one event per value
    wr(OFS_MOD_MODE_BASE, 32'h0000_004D);
    wr(OFS_MOD_VALUE_BASE, 32'h0000_0002);
    wr(OFS_EVT_ENABLE, 32'h0000_0001);
    pins.tick(2);
    repeat (5) @(posedge core_clk);
    chk({27'h0, pinOut & pinOe}, 32'h0000_0001);
    rc(OFS_EVT_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 1);
    // Comparator off: a step onto the compare value must do nothing
    wr(OFS_MOD_MODE_BASE, 32'h0000_000C);
    chk({31'h0, irq}, 0);
    wr(OFS_EVT_CLEAR, 32'h0000_0001);
    wr(OFS_COUNTER, 32'h0000_0001);
    pins.tick(1);
    @(posedge core_clk);
    chk({27'h0, pinOut & pinOe}, 32'h0000_0001);
    rc(OFS_EVT_STATUS, 32'h0000_0000);
    wr(OFS_MOD_MODE_BASE, 32'h0000_0000);
    wr(OFS_EVT_CLEAR, 32'h0000_003F);
    // Captures: module 1 on rise, module 2 on fall only
    wr(OFS_RUN_FLAGS, 32'h0000_0000);
    wr(OFS_COUNTER, 32'h0000_1234);
    wr(OFS_MOD_MODE_BASE + 8'h04, 32'h0000_0020);
    wr(OFS_MOD_MODE_BASE + 8'h08, 32'h0000_0010);
    pins.setPin(2, 1'b1);
    pins.setPin(1, 1'b1);
    rc(OFS_EVT_STATUS, 32'h0000_0002);
    wr(OFS_COUNTER, 32'h0000_0055);
    pins.setPin(2, 1'b0);
    pins.setPin(1, 1'b0);
    rc(OFS_MOD_VALUE_BASE + 8'h04, 32'h0000_1234);
    rc(OFS_MOD_VALUE_BASE + 8'h08, 32'h0000_0055);
    rc(OFS_EVT_STATUS, 32'h0000_0006);
    wr(OFS_EVT_CLEAR, 32'h0000_003F);
    // Idle stop and run control
    wr(OFS_ARRAY_MODE, 32'h0000_0084);
    wr(OFS_COUNTER, 32'h0000_0010);
    wr(OFS_RUN_FLAGS, 32'h0000_0040);
    idleMode <= 1'b1;
    pins.tick(2);
    rc(OFS_COUNTER, 32'h0000_0010);
    idleMode <= 1'b0;
    pins.tick(1);
    rc(OFS_COUNTER, 32'h0000_0011);
    wr(OFS_RUN_FLAGS, 32'h0000_0000);
    pins.tick(1);
    rc(OFS_COUNTER, 32'h0000_0011);
    // PWM on module 3: pin follows low byte against duty value
    wr(OFS_MOD_MODE_BASE + 8'h0C, 32'h0000_0042);
    wr(OFS_MOD_VALUE_BASE + 8'h0C, 32'h0000_8080);
    wr(OFS_COUNTER, 32'h0000_0090);
    chk({27'h0, pinOut & pinOe}, 32'h0000_0008);
    wr(OFS_COUNTER, 32'h0000_0010);
    chk({27'h0, pinOe}, 32'h0000_0008);
    chk({27'h0, pinOut & pinOe}, 32'h0000_0000);
    // Watchdog on module 4, then with the enable off
    wr(OFS_ARRAY_MODE, 32'h0000_0044);
    wr(OFS_MOD_MODE_BASE + 8'h10, 32'h0000_0048);
    wr(OFS_MOD_VALUE_BASE + 8'h10, 32'h0000_0005);
    wr(OFS_COUNTER, 32'h0000_0004);
    wr(OFS_RUN_FLAGS, 32'h0000_0040);
    pins.tick(1);
    rc(OFS_EVT_STATUS, 32'h0000_0010);
    chk(wdPulses, 1);
    wr(OFS_ARRAY_MODE, 32'h0000_0004);
    wr(OFS_COUNTER, 32'h0000_0004);
    pins.tick(1);
    chk(wdPulses, 1);
    summarize();
  end
endmodule : prgca_counter_array_tb_top
